// ---- core/pmlc_pkg.sv ----
package pmlc_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 24;
  localparam int TALLY_W = 16;

  // ****************************************
  // Register offsets and reset values
  // ****************************************
  localparam logic [4:0] OFS_FRAC = 5'h04;
  localparam logic [4:0] OFS_NSC = 5'h06;
  localparam logic [4:0] OFS_LWC = 5'h07;
  localparam logic [4:0] OFS_AEC = 5'h08;
  localparam logic [23:0] RST_FRAC = 24'h000000;
  localparam logic [23:0] RST_NSC = 24'h030f0a;
  localparam logic [23:0] RST_LWC = 24'h200844;
  localparam logic [23:0] RST_AEC = 24'h01bfff;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int NSC_ORDER_LO = 2;
  localparam int NSC_BYPASS = 7;
  localparam int NSC_AUTOSEED = 8;
  localparam int NSC_SHAPER_EN = 11;
  localparam int LWC_WIN_LO = 0;
  localparam int LWC_LOCK_EN = 11;
  localparam int LWC_TRAIN = 20;
  localparam int LWC_SLIP_GUARD = 21;
  localparam int AEC_OUT_EN = 5;
  localparam int AEC_VCO_BIAS = 10;
  localparam int AEC_HF_REF = 21;
  localparam int AEC_LEVEL = 22;

  // ****************************************
  // Lock tally targets per window code
  // ****************************************
  localparam logic [15:0] LOCK_CNT_0 = 16'h0005;
  localparam logic [15:0] LOCK_CNT_1 = 16'h0020;
  localparam logic [15:0] LOCK_CNT_2 = 16'h0060;
  localparam logic [15:0] LOCK_CNT_3 = 16'h0100;
  localparam logic [15:0] LOCK_CNT_4 = 16'h0200;
  localparam logic [15:0] LOCK_CNT_5 = 16'h0800;
  localparam logic [15:0] LOCK_CNT_6 = 16'h2000;
  localparam logic [15:0] LOCK_CNT_7 = 16'hffff;

  typedef enum logic [1:0] {
    PMLC_LK_OFF = 2'b00,
    PMLC_LK_HUNT = 2'b01,
    PMLC_LK_LOCK = 2'b11
  } pmlc_lk_state_t;
endpackage

// ---- core/pmlc_lock_det.sv ----
`timescale 1ns/100ps
module pmlc_lock_det import pmlc_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic lock_enable,
  input wire logic [2:0] win_code,
  input wire logic train_start,
  input wire logic cnt_valid,
  input wire logic cnt_in_window,
  output logic lock_out,
  output logic [15:0] tally_out
);
  typedef struct packed {
    pmlc_lk_state_t state;
    logic [15:0] tally;
    logic lock;
  } pmlc_lk_reg_t;

  pmlc_lk_reg_t cur_ff;
  pmlc_lk_reg_t nxt_lk;
  logic [15:0] target;

  always_comb begin
    case (win_code)
      3'h0: target = LOCK_CNT_0;
      3'h1: target = LOCK_CNT_1;
      3'h2: target = LOCK_CNT_2;
      3'h3: target = LOCK_CNT_3;
      3'h4: target = LOCK_CNT_4;
      3'h5: target = LOCK_CNT_5;
      3'h6: target = LOCK_CNT_6;
      default: target = LOCK_CNT_7;
    endcase
  end

  always_comb begin
    nxt_lk = cur_ff;
    if (!lock_enable) begin
      nxt_lk.state = PMLC_LK_OFF;
      nxt_lk.tally = 16'h0000;
      nxt_lk.lock = 1'b0;
    end else if (train_start) begin
      // Training throws away any tally built on the old detector rate
      nxt_lk.state = PMLC_LK_HUNT;
      nxt_lk.tally = 16'h0000;
      nxt_lk.lock = 1'b0;
    end else begin
      case (cur_ff.state)
        PMLC_LK_OFF: begin
          nxt_lk.state = PMLC_LK_HUNT;
        end
        PMLC_LK_HUNT, PMLC_LK_LOCK: begin
          if (cnt_valid && cnt_in_window) begin
            if (cur_ff.tally != 16'hffff) begin
              nxt_lk.tally = cur_ff.tally + 16'h0001;
            end
            if (cur_ff.tally + 16'h0001 >= target && cur_ff.tally != 16'hffff) begin
              nxt_lk.state = PMLC_LK_LOCK;
              nxt_lk.lock = 1'b1;
            end else if (cur_ff.tally == 16'hffff) begin
              nxt_lk.state = PMLC_LK_LOCK;
              nxt_lk.lock = 1'b1;
            end
          end else if (cnt_valid) begin
            nxt_lk.state = PMLC_LK_HUNT;
            nxt_lk.tally = 16'h0000;
            nxt_lk.lock = 1'b0;
          end
        end
        default: begin
          nxt_lk.state = PMLC_LK_OFF;
          nxt_lk.tally = 16'h0000;
          nxt_lk.lock = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '{state: PMLC_LK_OFF, tally: 16'h0000, lock: 1'b0};
    end else begin
      cur_ff <= nxt_lk;
    end
  end

  assign lock_out = cur_ff.lock;
  assign tally_out = cur_ff.tally;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_miss;
    lock_enable && !train_start && cnt_valid && !cnt_in_window;
  endsequence

  AST_MISS_DROPS_LOCK: assert property (s_miss |=> !lock_out && tally_out == 16'h0000)
    else $error("Out-of-window count did not clear lock");
  AST_LOCK_NEEDS_TALLY: assert property ($rose(lock_out) |-> tally_out >= target)
    else $error("Lock declared before selected count");
  AST_DISABLED_NO_LOCK: assert property (!lock_enable |=> !lock_out)
    else $error("Lock shown while detector disabled");
  AST_TRAIN_CLEARS: assert property (lock_enable && train_start |=> tally_out == 16'h0000)
    else $error("Training did not restart tally");
endmodule // pmlc_lock_det

// ---- core/pmlc_ctrl.sv ----
`timescale 1ns/100ps
module pmlc_ctrl import pmlc_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic pin_mode_always,
  input wire logic [2:0] chip_address,
  input wire logic serial_out_data,
  input wire logic modulator_step,
  input wire logic cnt_valid,
  input wire logic cnt_in_window,
  input wire logic phase_err_large,
  output logic div_use_modulator,
  output logic div_frac_step,
  output logic shaper_core_en,
  output logic [1:0] shaper_order,
  output logic shaper_seed_load,
  output logic [DATA_W-1:0] frac_word,
  output logic lock_indicator,
  output logic cp_boost,
  output logic pin_out,
  output logic pin_oe_n,
  output logic pin_level_3v,
  output logic ext_vco_bias_en,
  output logic hf_ref_sel
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [23:0] frac;
    logic [23:0] nsc;
    logic [23:0] lwc;
    logic [23:0] aec;
    logic [23:0] rdata;
    logic seed_load;
    logic train;
    logic step;
    logic boost;
    logic pin;
    logic oe_n;
  } pmlc_ctrl_reg_t;

  pmlc_ctrl_reg_t cur_ff;
  pmlc_ctrl_reg_t nxt_ctl;
  logic lock_raw;
  logic drive_pin;

  always_comb begin
    nxt_ctl = cur_ff;
    nxt_ctl.seed_load = 1'b0;
    nxt_ctl.train = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        OFS_FRAC: begin
          nxt_ctl.frac = reg_wdata;
          // Without autoseed the modulator keeps its phase across the write
          nxt_ctl.seed_load = cur_ff.nsc[NSC_AUTOSEED];
        end
        OFS_NSC: nxt_ctl.nsc = reg_wdata;
        OFS_LWC: begin
          nxt_ctl.lwc = reg_wdata;
          nxt_ctl.train = reg_wdata[LWC_TRAIN] && !cur_ff.lwc[LWC_TRAIN];
        end
        OFS_AEC: nxt_ctl.aec = reg_wdata;
        default: nxt_ctl.rdata = cur_ff.rdata;
      endcase
    end
    case (reg_addr)
      OFS_FRAC: nxt_ctl.rdata = cur_ff.frac;
      OFS_NSC: nxt_ctl.rdata = cur_ff.nsc;
      OFS_LWC: nxt_ctl.rdata = cur_ff.lwc;
      OFS_AEC: nxt_ctl.rdata = cur_ff.aec;
      default: nxt_ctl.rdata = 24'h000000;
    endcase
    // Divider sees no modulator steps after the first cycle of integer mode
    nxt_ctl.step = !cur_ff.nsc[NSC_BYPASS] && modulator_step;
    nxt_ctl.boost = cur_ff.lwc[LWC_SLIP_GUARD] && phase_err_large;
    drive_pin = cur_ff.aec[AEC_OUT_EN]
      && (pin_mode_always || chip_address == 3'h0);
    nxt_ctl.oe_n = !drive_pin;
    nxt_ctl.pin = pin_mode_always ? lock_raw : serial_out_data;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '{frac: RST_FRAC, nsc: RST_NSC, lwc: RST_LWC, aec: RST_AEC,
                  rdata: 24'h000000, seed_load: 1'b0, train: 1'b0, step: 1'b0,
                  boost: 1'b0, pin: 1'b0, oe_n: 1'b1};
    end else begin
      cur_ff <= nxt_ctl;
    end
  end

  // ****************************************
  // Lock detector
  // ****************************************
  pmlc_lock_det u_lock_det (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .lock_enable(cur_ff.lwc[LWC_LOCK_EN]),
    .win_code(cur_ff.lwc[LWC_WIN_LO +: 3]),
    .train_start(cur_ff.train),
    .cnt_valid(cnt_valid),
    .cnt_in_window(cnt_in_window),
    .lock_out(lock_raw),
    .tally_out()
  );

  assign reg_rdata = cur_ff.rdata;
  assign div_use_modulator = !cur_ff.nsc[NSC_BYPASS];
  assign div_frac_step = cur_ff.step;
  assign shaper_core_en = cur_ff.nsc[NSC_SHAPER_EN];
  assign shaper_order = cur_ff.nsc[NSC_ORDER_LO +: 2];
  assign shaper_seed_load = cur_ff.seed_load;
  assign frac_word = cur_ff.frac;
  assign lock_indicator = lock_raw;
  assign cp_boost = cur_ff.boost;
  assign pin_out = cur_ff.pin;
  assign pin_oe_n = cur_ff.oe_n;
  assign pin_level_3v = cur_ff.aec[AEC_LEVEL];
  assign ext_vco_bias_en = cur_ff.aec[AEC_VCO_BIAS];
  assign hf_ref_sel = cur_ff.aec[AEC_HF_REF];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_frac_write;
    reg_wr && reg_addr == OFS_FRAC;
  endsequence
  sequence s_train_write;
    reg_wr && reg_addr == OFS_LWC && reg_wdata[LWC_TRAIN];
  endsequence
  sequence s_nsc_write;
    reg_wr && reg_addr == OFS_NSC;
  endsequence
  sequence s_aec_write;
    reg_wr && reg_addr == OFS_AEC;
  endsequence

  AST_BYPASS_IGNORES: assert property (!div_use_modulator |=> !div_frac_step)
    else $error("Divider took modulator step in bypass");
  // Back-to-back fractional writes may legally stretch the seed pulse
  AST_SEED_ON_WRITE: assert property (s_frac_write ##0 shaper_seed_load == 1'b0
      ##0 cur_ff.nsc[NSC_AUTOSEED] |=> shaper_seed_load
      ##1 (!shaper_seed_load || $past(reg_wr && reg_addr == OFS_FRAC)))
    else $error("Autoseed write did not load seed once");
  AST_NO_SEED: assert property (s_frac_write ##0 !cur_ff.nsc[NSC_AUTOSEED]
      |=> !shaper_seed_load)
    else $error("Seed loaded with autoseed off");
  AST_TRAIN_EDGE: assert property (cur_ff.train |-> $past(!cur_ff.lwc[LWC_TRAIN])
      && cur_ff.lwc[LWC_TRAIN])
    else $error("Training without rising bit");
  AST_TRAIN_FIRES: assert property (s_train_write ##0 !cur_ff.lwc[LWC_TRAIN] |=> cur_ff.train)
    else $error("Rising training bit ignored");
  AST_CSP_BOOST: assert property (phase_err_large && cur_ff.lwc[LWC_SLIP_GUARD]
      |=> cp_boost)
    else $error("Cycle-slip boost missing");
  AST_CSP_OFF: assert property (!cur_ff.lwc[LWC_SLIP_GUARD] |=> !cp_boost)
    else $error("Boost while guard disabled");
  AST_PIN_OFF: assert property (!cur_ff.aec[AEC_OUT_EN] |=> pin_oe_n)
    else $error("Pin driven with output enable off");
  AST_PIN_DRIVE: assert property (cur_ff.aec[AEC_OUT_EN] && pin_mode_always
      |=> !pin_oe_n && pin_out == $past(lock_raw))
    else $error("Pin not driven with lock in drive mode");
  AST_PIN_SHARED: assert property (cur_ff.aec[AEC_OUT_EN] && !pin_mode_always
      && chip_address != 3'h0 |=> pin_oe_n)
    else $error("Serial driver on for nonzero address");
  AST_SHAPER_EN: assert property (s_nsc_write
      |=> shaper_core_en == $past(reg_wdata[NSC_SHAPER_EN]))
    else $error("Modulator enable did not follow write");
  AST_BYPASS_WRITE: assert property (s_nsc_write
      |=> div_use_modulator == !$past(reg_wdata[NSC_BYPASS]))
    else $error("Divider source did not follow bypass write");
  AST_ORDER_WRITE: assert property (s_nsc_write
      |=> shaper_order == $past(reg_wdata[NSC_ORDER_LO +: 2]))
    else $error("Modulator order did not follow write");
  AST_FRAC_WRITE: assert property (s_frac_write |=> frac_word == $past(reg_wdata))
    else $error("Fractional word did not follow write");
  AST_BIAS_WRITE: assert property (s_aec_write
      |=> ext_vco_bias_en == $past(reg_wdata[AEC_VCO_BIAS]))
    else $error("Bias enable did not follow write");
  AST_LEVEL_WRITE: assert property (s_aec_write
      |=> pin_level_3v == $past(reg_wdata[AEC_LEVEL]))
    else $error("Pin level did not follow write");
endmodule // pmlc_ctrl

// ---- tb/pmlc_host.sv ----
`timescale 1ns/100ps
module pmlc_host import pmlc_pkg::*; (
  input wire logic mclk,
  input wire logic [DATA_W-1:0] reg_rdata,
  output logic reg_wr,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 24'h000000;
  end
  // Released data inverted so a stale word never looks valid
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, output logic [23:0] d);
    @(posedge mclk);
    reg_addr <= a;
    repeat (2) @(posedge mclk);
    #1;
    d = reg_rdata;
  endtask
  // A set-only write would not retrain
  task automatic retrain(input logic [23:0] v);
    wr(OFS_LWC, v & 24'hefffff);
    wr(OFS_LWC, v | 24'h100000);
  endtask
endmodule // pmlc_host

// ---- tb/pmlc_ctrl_tb.sv ----
`timescale 1ns/100ps
module pmlc_ctrl_tb import pmlc_pkg::*; ();
  logic mclk, sys_rst, reg_wr, pin_mode_always, serial_out_data, modulator_step;
  logic cnt_valid, cnt_in_window, phase_err_large, div_use_modulator, div_frac_step;
  logic shaper_core_en, shaper_seed_load, lock_indicator, cp_boost, pin_out, pin_oe_n;
  logic pin_level_3v, ext_vco_bias_en, hf_ref_sel;
  logic [1:0] shaper_order;
  logic [2:0] chip_address;
  logic [4:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata, frac_word, rv;
  int fail_count, cmp_count, cyc;
  logic [4:0] ra [5] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08};
  logic [23:0] rx [5] = '{24'h0, 24'h0, 24'h030f0a, 24'h200844, 24'h01bfff};
  int tg [3] = '{5, 32, 96};

  pmlc_ctrl u_pmlc_ctrl (.mclk, .sys_rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .pin_mode_always, .chip_address, .serial_out_data, .modulator_step, .cnt_valid,
    .cnt_in_window, .phase_err_large, .div_use_modulator, .div_frac_step, .shaper_core_en,
    .shaper_order, .shaper_seed_load, .frac_word, .lock_indicator, .cp_boost, .pin_out,
    .pin_oe_n, .pin_level_3v, .ext_vco_bias_en, .hf_ref_sel);
  pmlc_host u_pmlc_host (.mclk, .reg_rdata, .reg_wr, .reg_addr, .reg_wdata);

  always #4 mclk = ~mclk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic pulse(input int n, input logic w);
    repeat (n) begin
      @(posedge mclk);
      cnt_valid <= 1'b1;
      cnt_in_window <= w;
      @(posedge mclk);
      cnt_valid <= 1'b0;
    end
    @(posedge mclk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Bound well above the roughly 1000 cycles of traffic
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    mclk = 0;
    sys_rst = 1;
    {pin_mode_always, serial_out_data, modulator_step} = 3'h0;
    {cnt_valid, cnt_in_window, phase_err_large} = 3'h0;
    chip_address = 3'h0;
    fail_count = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    step();
    chk("oe_n", 0, pin_oe_n);
    chk("use_mod", 1, div_use_modulator);
    chk("core_en", 1, shaper_core_en);
    chk("order", 2, shaper_order);
    chk("bias", 1, ext_vco_bias_en);
    chk("level", 0, pin_level_3v);
    u_pmlc_host.wr(5'h05, 24'h5a5a5a);
    for (int i = 0; i < 5; i++) begin
      u_pmlc_host.rd(ra[i], rv);
      chk("rdata", rx[i], rv);
    end
    modulator_step <= 1'b1;
    u_pmlc_host.wr(OFS_FRAC, 24'h9a5c31);
    chk("seed", 1, shaper_seed_load);
    chk("frac", 24'h9a5c31, frac_word);
    step();
    chk("seed", 0, shaper_seed_load);
    u_pmlc_host.wr(OFS_NSC, 24'h030e86);
    step();
    chk("use_mod", 0, div_use_modulator);
    chk("step", 0, div_frac_step);
    chk("core_en", 1, shaper_core_en);
    chk("order", 1, shaper_order);
    u_pmlc_host.wr(OFS_FRAC, 24'h000001);
    chk("seed", 0, shaper_seed_load);
    u_pmlc_host.wr(OFS_NSC, 24'h030702);
    step();
    chk("use_mod", 1, div_use_modulator);
    chk("step", 1, div_frac_step);
    chk("core_en", 0, shaper_core_en);
    chk("order", 0, shaper_order);
    for (int i = 0; i < 3; i++) begin
      u_pmlc_host.wr(OFS_LWC, 24'h200840 | 24'(i));
      pulse(tg[i] - 1, 1'b1);
      chk("lock", 0, lock_indicator);
      pulse(1, 1'b1);
      chk("lock", 1, lock_indicator);
      pulse(1, 1'b0);
      chk("lock", 0, lock_indicator);
    end
    pulse(96, 1'b1);
    u_pmlc_host.retrain(24'h200842);
    step();
    chk("lock", 0, lock_indicator);
    pulse(96, 1'b1);
    u_pmlc_host.wr(OFS_LWC, 24'h300842);
    step();
    chk("lock", 1, lock_indicator);
    u_pmlc_host.wr(OFS_LWC, 24'h200842);
    step();
    chk("lock", 1, lock_indicator);
    pin_mode_always <= 1'b1;
    chip_address <= 3'h3;
    phase_err_large <= 1'b1;
    step();
    chk("oe_n", 0, pin_oe_n);
    chk("pin", 1, pin_out);
    chk("boost", 1, cp_boost);
    pin_mode_always <= 1'b0;
    step();
    chk("oe_n", 1, pin_oe_n);
    chip_address <= 3'h0;
    serial_out_data <= 1'b1;
    step();
    chk("oe_n", 0, pin_oe_n);
    chk("pin", 1, pin_out);
    u_pmlc_host.wr(OFS_LWC, 24'h000042);
    pulse(96, 1'b1);
    chk("lock", 0, lock_indicator);
    chk("boost", 0, cp_boost);
    // Crystal above 200 MHz assumed here
    u_pmlc_host.wr(OFS_AEC, 24'h61bbdf);
    step();
    chk("oe_n", 1, pin_oe_n);
    chk("bias", 0, ext_vco_bias_en);
    chk("hf", 1, hf_ref_sel);
    chk("level", 1, pin_level_3v);
    u_pmlc_host.rd(OFS_AEC, rv);
    chk("rdata", 24'h61bbdf, rv);
    tally_and_finish();
  end
endmodule // pmlc_ctrl_tb
